// ### core/tdm_port_regs.vh
// Constants for the time-division multiplexed serial channel port.
// Functional notes
// - The port runs either with separate receive and transmit lines, clocks and syncs, or with four data lines sharing one clock and sync.
// - The total rate stays within fifty megabits per second, so the bit clock may be 50, 25 or 12.5 MHz for one, two or four lines.
// - Up to 256 channels make a frame, and each channel has its own enable.
// - A channel buffer is up to sixteen megabytes in eight-byte steps, doubled with sixteen-byte steps when companding.
// - Every received word goes to one shared write offset above its own channel's base address.
// - Every transmitted word comes from one shared read offset above its own channel's base address.
// - One word size applies to all channels.
// - Words of two, four, eight or sixteen bits are stored at that same width.
// - Two receive and two transmit thresholds each raise an interrupt when reached.
// - Hardware converts between linear samples and A-law or mu-law words on request.
// - The transmit frame sync pin is either an input or an output driven by the port.
// - Sync and data are sampled on the rising or the falling bit clock edge as programmed.
// - The frame sync is active low or active high as programmed.
// - Zero to three bit periods pass between sync detection and the first bit of the frame; a transmit sync output gives one less for delays one to three.
// - Each word is shifted most significant bit first or least significant bit first as programmed.
`ifndef TDM_PORT_REGS_VH
`define TDM_PORT_REGS_VH
`define WSIZE_2 2'h0
`define WSIZE_4 2'h1
`define WSIZE_8 2'h2
`define WSIZE_16 2'h3
`define COMP_NONE 2'h0
`define COMP_ALAW 2'h1
`define COMP_ULAW 2'h2
`define MAX_CHANNELS 256
`define MAX_BUF_BYTES 25'h1000000
`define BUF_STEP_BYTES 8
`define BUF_STEP_COMP_BYTES 16
`define MAX_BITCLK_1LINE_MHZ 50
`define MAX_BITCLK_2LINE_MHZ 25
`define MAX_BITCLK_4LINE_KHZ 12500
`define CLOCK_MHZ 250
`endif

// ### core/tdm_compander.v
// Linear to companded conversion of one channel word, one way or the other.
`timescale 1ns/10ps
`default_nettype none
`include "tdm_port_regs.vh"
module tdm_compander (
  input wire [1:0] law,
  input wire [15:0] linear_in,
  input wire [7:0] code_in,
  output reg [7:0] code_out,
  output reg [15:0] linear_out
);
  reg [15:0] mag;
  reg [2:0] seg;
  reg [3:0] mant;
  reg [7:0] c;
  reg [15:0] m;
  integer i;
  always @* begin
    mag = linear_in[15] ? (~linear_in + 16'h0001) : linear_in;
    if (law == `COMP_ULAW) begin
      mag = (mag > 16'h7F7B) ? 16'h7FFF : (mag + 16'h0084);
    end
    // A-law segment one already starts at bit eight, so the search begins one step up.
    seg = 3'h0;
    for (i = 1; i < 8; i = i + 1) begin
      if (mag[i + 7]) begin
        seg = i[2:0];
      end
    end
    if (law == `COMP_ULAW) begin
      seg = 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
        if (mag[i + 7]) begin
          seg = i[2:0];
        end
      end
      mant = mag[{1'b0, seg} + 4'h3 +: 4];
      code_out = ~{linear_in[15], seg, mant};
    end else begin
      mant = (seg == 3'h0) ? mag[7:4] : mag[{1'b0, seg} + 4'h3 +: 4];
      code_out = {~linear_in[15], seg, mant} ^ 8'h55;
    end
    c = (law == `COMP_ULAW) ? ~code_in : (code_in ^ 8'h55);
    if (law == `COMP_ULAW) begin
      m = (({12'h000, c[3:0]} << 3) + 16'h0084) << c[6:4];
      m = m - 16'h0084;
      linear_out = c[7] ? (~m + 16'h0001) : m;
    end else begin
      m = {8'h00, c[3:0], 4'h8};
      if (c[6:4] != 3'h0) begin
        m = (m + 16'h0100) << (c[6:4] - 3'h1);
      end
      linear_out = c[7] ? m : (~m + 16'h0001);
    end
  end
endmodule
`default_nettype wire

// ### core/tdm_serial_channel_port.v
// Time-division multiplexed serial channel port: framing, slots, offsets and memory access.
`timescale 1ns/10ps
`default_nettype none
`include "tdm_port_regs.vh"
module tdm_serial_channel_port #(
  parameter CH_BITS = 8,
  parameter OFF_BITS = 24
) (
  input wire clock,
  input wire rst,
  input wire enable,
  input wire shared_mode,
  input wire [1:0] word_size,
  input wire [1:0] compand_law,
  input wire sample_falling,
  input wire sync_active_low,
  input wire [1:0] sync_delay,
  input wire lsb_first,
  input wire tx_sync_is_output,
  input wire [CH_BITS-1:0] last_channel,
  input wire [(1<<CH_BITS)-1:0] channel_active,
  input wire [OFF_BITS-1:0] buffer_words,
  input wire [OFF_BITS-1:0] rx_threshold_a,
  input wire [OFF_BITS-1:0] rx_threshold_b,
  input wire [OFF_BITS-1:0] tx_threshold_a,
  input wire [OFF_BITS-1:0] tx_threshold_b,
  input wire rx_bit_clock,
  input wire rx_frame_sync,
  input wire [3:0] rx_data,
  input wire tx_bit_clock,
  input wire transmit_frame_sync_pin_in,
  output reg transmit_frame_sync_pin_out,
  output reg transmit_frame_sync_pin_oe,
  output reg [3:0] tx_data,
  output reg [3:0] tx_data_oe,
  output reg rx_store_valid,
  output reg [CH_BITS-1:0] rx_store_channel,
  output reg [OFF_BITS-1:0] rx_store_offset,
  output reg [15:0] rx_store_word,
  output reg tx_fetch_req,
  output reg [CH_BITS-1:0] tx_fetch_channel,
  output reg [OFF_BITS-1:0] tx_fetch_offset,
  input wire [15:0] tx_fetch_word,
  output reg [OFF_BITS-1:0] rx_offset,
  output reg [OFF_BITS-1:0] tx_offset,
  output reg [3:0] threshold_irq
);
  localparam ST_IDLE = 3'b001;
  localparam ST_DELAY = 3'b010;
  localparam ST_RUN = 3'b100;

  // Bit count of one slot; companding sends eight-bit codes of sixteen-bit words.
  function [4:0] slot_bits;
    input [1:0] ws;
    input [1:0] law;
    begin
      if (law != `COMP_NONE) begin
        slot_bits = 5'd8;
      end else begin
        case (ws)
          `WSIZE_2: slot_bits = 5'd2;
          `WSIZE_4: slot_bits = 5'd4;
          `WSIZE_8: slot_bits = 5'd8;
          default: slot_bits = 5'd16;
        endcase
      end
    end
  endfunction

  function [OFF_BITS-1:0] next_off;
    input [OFF_BITS-1:0] cur;
    input [OFF_BITS-1:0] size;
    begin
      next_off = (cur + 1'b1 >= size) ? {OFF_BITS{1'b0}} : cur + 1'b1;
    end
  endfunction

  // Two flip-flops on every pin, plus a third on each bit clock to find its edges; the first stage is never looked at.
  reg [1:0] rclk_s1, rclk_s2;
  reg [1:0] fs_s1, fs_s2;
  reg [3:0] rd_s1, rd_s2;
  reg rclk_prev, tclk_prev;
  always @(posedge clock) begin
    rclk_s1 <= {tx_bit_clock, rx_bit_clock};
    rclk_s2 <= rclk_s1;
    fs_s1 <= {transmit_frame_sync_pin_in, rx_frame_sync};
    fs_s2 <= fs_s1;
    rd_s1 <= rx_data;
    rd_s2 <= rd_s1;
    rclk_prev <= rclk_s2[0];
    tclk_prev <= rclk_s2[1];
  end

  // In shared mode both sections follow the receive clock, and the receive sync unless the transmit sync is an output.
  wire rclk = rclk_s2[0];
  wire tclk = shared_mode ? rclk_s2[0] : rclk_s2[1];
  wire tclk_p = shared_mode ? rclk_prev : tclk_prev;
  wire rx_rise = rclk & ~rclk_prev;
  wire rx_fall = ~rclk & rclk_prev;
  wire tx_rise = tclk & ~tclk_p;
  wire tx_fall = ~tclk & tclk_p;
  wire rx_samp = sample_falling ? rx_fall : rx_rise;
  wire tx_samp = sample_falling ? tx_fall : tx_rise;
  wire tx_drive = sample_falling ? tx_rise : tx_fall;
  wire rx_fs = fs_s2[0] ^ sync_active_low;
  wire tx_fs_in = (shared_mode ? fs_s2[0] : fs_s2[1]) ^ sync_active_low;
  wire [2:0] lanes = shared_mode ? 3'd4 : 3'd1;
  wire [4:0] nbits = slot_bits(word_size, compand_law);

  wire [15:0] exp_word;
  wire [7:0] enc_code;
  reg [15:0] rx_shift;
  reg [15:0] tx_shift;
  reg [15:0] rx_lin;
  wire [15:0] rx_next = shared_mode ? {rx_shift[11:0], rd_s2} : {rx_shift[14:0], rd_s2[0]};
  tdm_compander u_comp (
    .law(compand_law),
    .linear_in(tx_fetch_word),
    .code_in(rx_lin[7:0]),
    .code_out(enc_code),
    .linear_out(exp_word)
  );

  // Receive section.
  reg [2:0] rst_reg;
  reg [1:0] rdly_reg;
  reg [4:0] rbit_reg;
  reg [CH_BITS-1:0] rch_reg;
  integer k;
  always @* begin
    rx_lin = 16'h0000;
    for (k = 0; k < 16; k = k + 1) begin
      if (k < nbits) begin
        rx_lin[k] = lsb_first ? rx_next[nbits - 1 - k] : rx_next[k];
      end
    end
  end
  always @(posedge clock) begin
    rx_store_valid <= 1'b0;
    if (rst || !enable) begin
      rst_reg <= ST_IDLE;
      rdly_reg <= 2'h0;
      rbit_reg <= 5'h0;
      rch_reg <= {CH_BITS{1'b0}};
      rx_shift <= 16'h0000;
      rx_offset <= {OFF_BITS{1'b0}};
      rx_store_channel <= {CH_BITS{1'b0}};
      rx_store_offset <= {OFF_BITS{1'b0}};
      rx_store_word <= 16'h0000;
    end else if (rx_samp) begin
      case (rst_reg)
        ST_IDLE: begin
          if (rx_fs) begin
            rdly_reg <= sync_delay;
            rst_reg <= (sync_delay == 2'h0) ? ST_RUN : ST_DELAY;
            rbit_reg <= 5'h0;
            rch_reg <= {CH_BITS{1'b0}};
          end
        end
        ST_DELAY: begin
          rdly_reg <= rdly_reg - 2'h1;
          if (rdly_reg == 2'h1) begin
            rst_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          rx_shift <= rx_next;
          if (rbit_reg + {2'b00, lanes} >= nbits) begin
            rbit_reg <= 5'h0;
            rch_reg <= rch_reg + 1'b1;
            if (rch_reg == last_channel) begin
              rst_reg <= ST_IDLE;
              rx_offset <= next_off(rx_offset, buffer_words);
            end
          end else begin
            rbit_reg <= rbit_reg + {2'b00, lanes};
          end
        end
        default: rst_reg <= ST_IDLE;
      endcase
    end
    // A slot is stored at the edge that samples its last bit, so the last slot of a frame
    // is not lost when the section drops back to idle.
    if (!rst && enable && rst_reg == ST_RUN && rx_samp &&
        rbit_reg + {2'b00, lanes} >= nbits && channel_active[rch_reg]) begin
      rx_store_valid <= 1'b1;
      rx_store_channel <= rch_reg;
      rx_store_offset <= rx_offset;
      rx_store_word <= (compand_law != `COMP_NONE) ? exp_word : rx_lin;
    end
  end

  // Transmit section; the word for a slot is fetched at the slot start.
  reg [2:0] tst_reg;
  reg [1:0] tdly_reg;
  reg [4:0] tbit_reg;
  reg [CH_BITS-1:0] tch_reg;
  reg [4:0] fs_cnt_reg;
  reg [15:0] tx_ord;
  reg [15:0] tx_src;
  always @* begin
    tx_src = (compand_law != `COMP_NONE) ? {8'h00, enc_code} : tx_fetch_word;
    tx_ord = 16'h0000;
    for (k = 0; k < 16; k = k + 1) begin
      if (k < nbits) begin
        tx_ord[k] = lsb_first ? tx_src[nbits - 1 - k] : tx_src[k];
      end
    end
  end
  // Inactive slots send zeros from their very first bit.
  wire [15:0] tx_load = channel_active[tch_reg] ? tx_ord : 16'h0000;
  wire tx_fs = tx_sync_is_output ? (tst_reg == ST_IDLE && tx_drive) : tx_fs_in;
  always @(posedge clock) begin
    if (rst || !enable) begin
      tst_reg <= ST_IDLE;
      tdly_reg <= 2'h0;
      tbit_reg <= 5'h0;
      tch_reg <= {CH_BITS{1'b0}};
      tx_shift <= 16'h0000;
      tx_offset <= {OFF_BITS{1'b0}};
      tx_fetch_req <= 1'b0;
      tx_fetch_channel <= {CH_BITS{1'b0}};
      tx_fetch_offset <= {OFF_BITS{1'b0}};
      tx_data <= 4'h0;
      tx_data_oe <= 4'h0;
      transmit_frame_sync_pin_out <= 1'b0;
      transmit_frame_sync_pin_oe <= 1'b0;
      fs_cnt_reg <= 5'h0;
    end else begin
      transmit_frame_sync_pin_oe <= tx_sync_is_output;
      tx_data_oe <= (tst_reg == ST_RUN) ? (shared_mode ? 4'hF : 4'h1) : 4'h0;
      if (tx_drive && tst_reg == ST_IDLE && tx_sync_is_output) begin
        transmit_frame_sync_pin_out <= ~sync_active_low;
        fs_cnt_reg <= 5'h1;
      end else if (tx_drive && fs_cnt_reg != 5'h0) begin
        transmit_frame_sync_pin_out <= sync_active_low;
        fs_cnt_reg <= 5'h0;
      end else if (fs_cnt_reg == 5'h0) begin
        transmit_frame_sync_pin_out <= sync_active_low;
      end
      tx_fetch_req <= (tst_reg == ST_RUN) && tbit_reg == 5'h0 && channel_active[tch_reg];
      tx_fetch_channel <= tch_reg;
      tx_fetch_offset <= tx_offset;
      if ((tst_reg == ST_IDLE) ? (tx_sync_is_output ? tx_fs : tx_samp && tx_fs) : 1'b0) begin
        tdly_reg <= sync_delay;
        tst_reg <= (sync_delay == 2'h0) ? ST_RUN : ST_DELAY;
        tbit_reg <= 5'h0;
        tch_reg <= {CH_BITS{1'b0}};
      end else if (tst_reg == ST_DELAY && tx_samp) begin
        tdly_reg <= tdly_reg - 2'h1;
        if (tdly_reg == 2'h1) begin
          tst_reg <= ST_RUN;
        end
      end else if (tst_reg == ST_RUN && tx_drive) begin
        if (tbit_reg == 5'h0) begin
          tx_shift <= tx_load;
        end else begin
          tx_shift <= shared_mode ? {tx_shift[11:0], 4'h0} : {tx_shift[14:0], 1'b0};
        end
        tx_data <= (tbit_reg == 5'h0) ?
          (shared_mode ? tx_load[nbits - 1 -: 4] : {3'h0, tx_load[nbits - 1]}) :
          (shared_mode ? tx_shift[nbits - 5 -: 4] : {3'h0, tx_shift[nbits - 2]});
        if (tbit_reg + {2'b00, lanes} >= nbits) begin
          tbit_reg <= 5'h0;
          tch_reg <= tch_reg + 1'b1;
          if (tch_reg == last_channel) begin
            tst_reg <= ST_IDLE;
            tx_offset <= next_off(tx_offset, buffer_words);
          end
        end else begin
          tbit_reg <= tbit_reg + {2'b00, lanes};
        end
      end
    end
  end

  // Threshold events pulse once when an offset steps onto a programmed level.
  reg [OFF_BITS-1:0] rx_off_prev, tx_off_prev;
  always @(posedge clock) begin
    if (rst) begin
      rx_off_prev <= {OFF_BITS{1'b0}};
      tx_off_prev <= {OFF_BITS{1'b0}};
      threshold_irq <= 4'h0;
    end else begin
      rx_off_prev <= rx_offset;
      tx_off_prev <= tx_offset;
      threshold_irq[0] <= rx_offset != rx_off_prev && rx_offset == rx_threshold_a;
      threshold_irq[1] <= rx_offset != rx_off_prev && rx_offset == rx_threshold_b;
      threshold_irq[2] <= tx_offset != tx_off_prev && tx_offset == tx_threshold_a;
      threshold_irq[3] <= tx_offset != tx_off_prev && tx_offset == tx_threshold_b;
    end
  end
endmodule
`default_nettype wire

// ### verif/tdm_port_properties.sv
// Concurrent checks on the serial channel port outputs.
`timescale 1ns/10ps
`default_nettype none
module tdm_port_properties #(parameter CH_BITS = 8, parameter OFF_BITS = 24) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic shared_mode,
  input wire logic tx_sync_is_output,
  input wire logic [(1<<CH_BITS)-1:0] channel_active,
  input wire logic [OFF_BITS-1:0] buffer_words,
  input wire logic [OFF_BITS-1:0] rx_threshold_a,
  input wire logic [OFF_BITS-1:0] rx_threshold_b,
  input wire logic transmit_frame_sync_pin_oe,
  input wire logic [3:0] tx_data_oe,
  input wire logic rx_store_valid,
  input wire logic [CH_BITS-1:0] rx_store_channel,
  input wire logic [OFF_BITS-1:0] rx_store_offset,
  input wire logic tx_fetch_req,
  input wire logic [CH_BITS-1:0] tx_fetch_channel,
  input wire logic [OFF_BITS-1:0] tx_fetch_offset,
  input wire logic [OFF_BITS-1:0] rx_offset,
  input wire logic [OFF_BITS-1:0] tx_offset,
  input wire logic [3:0] threshold_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_store_pulse: assert property (rx_store_valid |=> !rx_store_valid)
    else $error("store strobe too long");
  chk_store_active: assert property (rx_store_valid |-> channel_active[rx_store_channel])
    else $error("store from inactive slot");
  chk_fetch_active: assert property (tx_fetch_req |-> channel_active[tx_fetch_channel])
    else $error("fetch for inactive slot");
  chk_fetch_offset: assert property (tx_fetch_req |-> tx_fetch_offset == tx_offset)
    else $error("fetch off shared offset");
  chk_offset_wrap: assert property (rx_offset < buffer_words && rx_store_offset < buffer_words)
    else $error("offset past buffer size");
  chk_offset_step: assert property ($changed(rx_offset) |->
    rx_offset == '0 || rx_offset == $past(rx_offset) + 1'b1) else $error("offset jumped");
  chk_irq_rx_a: assert property (threshold_irq[0] |->
    rx_offset == rx_threshold_a || $past(rx_offset) == rx_threshold_a) else $error("irq a early");
  chk_irq_rx_b: assert property (threshold_irq[1] |->
    rx_offset == rx_threshold_b || $past(rx_offset) == rx_threshold_b) else $error("irq b early");
  chk_sync_oe: assert property (!$past(rst) && $past(enable) && enable |->
    transmit_frame_sync_pin_oe == $past(tx_sync_is_output)) else $error("sync enable wrong");
  chk_lane_unused: assert property (!shared_mode && !$past(shared_mode) |->
    tx_data_oe[3:1] == 3'h0) else $error("spare lane driven");
endmodule
`default_nettype wire

// ### verif/tdm_framer_model.sv
// Framer model: bit clock, frame sync and receive lanes of the far side.
`timescale 1ns/10ps
`default_nettype none
module tdm_framer_model (
  output logic bit_clock,
  output logic frame_sync,
  output logic [3:0] lanes
);
  localparam logic [63:0] PAT = 64'h0F96F0699F066F90;
  int hp = 24;
  logic [3:0] held = 4'h0;
  initial begin
    bit_clock = 1'b0;
    frame_sync = 1'b0;
    lanes = 4'h0;
  end
  // Nibbles are bit palindromes, so the word reads the same whichever lane leads.
  function automatic logic [15:0] word(input int ch, input int fr);
    return PAT[16 * ((ch + fr) % 4) +: 16];
  endfunction
  // The model changes lines on the edge opposite the sampling one.
  task automatic period(input logic [3:0] d, input logic s, input logic fall);
    if (fall) bit_clock = 1'b1;
    lanes = d;
    frame_sync = s;
    #(hp) bit_clock = !fall;
    #(hp) bit_clock = 1'b0;
  endtask
  task automatic frame(input int slots, input int bits, input int nl, input int dly,
                       input int fr, input logic low, input logic lsb, input logic fall);
    logic [15:0] w;
    period(4'h5, low, fall);
    period(4'hA, low, fall);
    period(4'h5, !low, fall);
    for (int k = 0; k < dly; k++) period(4'hA, low, fall);
    for (int s = 0; s < slots; s++) begin
      w = word(s, fr);
      for (int k = 0; k < bits / nl; k++) begin
        if (nl == 4) held = w[15 - 4 * k -: 4];
        else held = {3'h0, lsb ? w[k] : w[bits - 1 - k]};
        period(held, low, fall);
      end
    end
    repeat (3) period(~held, low, fall);
  endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// Testbench of the serial channel port driven by the framer model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic enable = 1'b1;
  logic shared_mode = 1'b0;
  logic [1:0] word_size = 2'h0;
  logic sample_falling = 1'b0;
  logic sync_active_low = 1'b0;
  logic [1:0] sync_delay = 2'h0;
  logic lsb_first = 1'b0;
  logic tx_sync_is_output = 1'b0;
  logic [3:0] last_channel = 4'h3;
  logic [7:0] thr_a = 8'h01;
  logic [7:0] thr_b = 8'h02;
  wire logic bclk;
  wire logic fsync;
  wire logic [3:0] lanes;
  logic transmit_frame_sync_pin_oe, rx_store_valid, tx_fetch_req, fetch_prev;
  logic [3:0] rx_store_channel, tx_fetch_channel, threshold_irq;
  logic [7:0] rx_store_offset, tx_fetch_offset, rx_offset, tx_offset;
  logic [15:0] rx_store_word, tx_fetch_word;
  logic [15:0] got_word [$];
  logic [3:0] got_ch [$];
  logic [7:0] got_off [$];
  logic [8:0] cfgs [6] = '{9'h002, 9'h054, 9'h129, 9'h07F, 9'h083, 9'h0DB};
  int irq_exp [4] = '{2, 1, 1, 2};
  int irq_n [4];
  int fetches, errors, samples_checked, cycles;
  // Memory contents tie each fetched word to its channel and offset.
  assign tx_fetch_word = {4'hC, tx_fetch_channel, tx_fetch_offset};
  tdm_framer_model model (.bit_clock(bclk), .frame_sync(fsync), .lanes);
  tdm_serial_channel_port #(.CH_BITS(4), .OFF_BITS(8)) DUT (
    .clock, .rst, .enable, .shared_mode, .word_size, .compand_law(2'h0), .sample_falling,
    .sync_active_low, .sync_delay, .lsb_first, .tx_sync_is_output, .last_channel,
    .channel_active(16'h000B), .buffer_words(8'h03), .rx_threshold_a(thr_a),
    .rx_threshold_b(thr_b), .tx_threshold_a(thr_b), .tx_threshold_b(thr_a),
    .rx_bit_clock(bclk), .rx_frame_sync(fsync), .rx_data(lanes), .tx_bit_clock(bclk),
    .transmit_frame_sync_pin_in(fsync), .transmit_frame_sync_pin_out(),
    .transmit_frame_sync_pin_oe, .tx_data(), .tx_data_oe(), .rx_store_valid,
    .rx_store_channel, .rx_store_offset, .rx_store_word, .tx_fetch_req, .tx_fetch_channel,
    .tx_fetch_offset, .tx_fetch_word, .rx_offset, .tx_offset, .threshold_irq);
  always #2 clock = ~clock;
  always @(posedge clock) begin
    fetch_prev <= tx_fetch_req;
    if (tx_fetch_req === 1'b1 && fetch_prev !== 1'b1) fetches++;
    for (int i = 0; i < 4; i++) if (threshold_irq[i] === 1'b1) irq_n[i]++;
    if (rx_store_valid === 1'b1) begin
      got_word.push_back(rx_store_word);
      got_ch.push_back(rx_store_channel);
      got_off.push_back(rx_store_offset);
    end
  end
  task automatic wrap_up();
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Each setup is loaded under reset, so no frame sees a half-changed format.
  task automatic run_cfg(input logic [8:0] c);
    int bits, slots, per, ch, fr;
    logic [15:0] mask;
    @(posedge clock);
    #1;
    rst = 1'b1;
    {tx_sync_is_output, shared_mode, sample_falling, lsb_first, sync_active_low, sync_delay,
      word_size} = c;
    bits = 2 << c[1:0];
    slots = c[7] ? 2 : 4;
    per = c[7] ? 2 : 3;
    mask = 16'hFFFF >> (16 - bits);
    last_channel = 4'(slots - 1);
    model.hp = c[7] ? 40 : 24;
    got_word.delete();
    got_ch.delete();
    got_off.delete();
    fetches = 0;
    irq_n = '{0, 0, 0, 0};
    repeat (2) @(posedge clock);
    #1;
    rst = 1'b0;
    for (fr = 0; fr < 4; fr++) begin
      model.frame(slots, bits, c[7] ? 4 : 1, c[3:2], fr, c[4], c[5], c[6]);
      #200;
    end
    repeat (30) @(posedge clock);
    `CHK(got_word.size(), 4 * per)
    for (int i = 0; i < got_word.size() && i < 4 * per; i++) begin
      fr = i / per;
      ch = (i % per == 2) ? 3 : i % per;
      `CHK(got_ch[i], ch[3:0])
      `CHK(got_word[i], model.word(ch, fr) & mask)
      `CHK(got_off[i], 8'(fr % 3))
    end
    `CHK(rx_offset, 8'h01)
    `CHK(transmit_frame_sync_pin_oe, c[8])
    for (int i = 0; i < 4; i++) if (i < 2 || !c[8]) `CHK(irq_n[i], irq_exp[i])
    if (!c[8]) `CHK(fetches, 4 * per)
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles > 40000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    for (int i = 0; i < 6; i++) run_cfg(cfgs[i]);
    wrap_up();
  end
endmodule
bind tdm_serial_channel_port tdm_port_properties #(.CH_BITS(CH_BITS), .OFF_BITS(OFF_BITS)) props (
  .clock, .rst, .enable, .shared_mode, .tx_sync_is_output, .channel_active, .buffer_words,
  .rx_threshold_a, .rx_threshold_b, .transmit_frame_sync_pin_oe, .tx_data_oe, .rx_store_valid,
  .rx_store_channel, .rx_store_offset, .tx_fetch_req, .tx_fetch_channel, .tx_fetch_offset,
  .rx_offset, .tx_offset, .threshold_irq);
`default_nettype wire
